// ---- dspace_pkg.sv ----
// constants and types for the data-space map
package dspace_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int ROM_ADDR_W = 13;
  localparam int WIN_OFS_W = 6;
  localparam int WIN_PAGE_W = 7;
  localparam int BANK_DEPTH = 64;
  localparam int BANK_COUNT = 3;
  localparam int RAM_HI_DEPTH = 60;

  localparam logic [7:0] ADDR_BANK_LO = 8'h00;
  localparam logic [7:0] ADDR_BANK_HI = 8'h3f;
  localparam logic [7:0] ADDR_WIN_LO = 8'h40;
  localparam logic [7:0] ADDR_WIN_HI = 8'h7f;
  localparam logic [7:0] ADDR_PTR_FIRST = 8'h80;
  localparam logic [7:0] ADDR_PTR_SECOND = 8'h81;
  localparam logic [7:0] ADDR_SD_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SD_SECOND = 8'h83;
  localparam logic [7:0] ADDR_RAM_LO = 8'h84;
  localparam logic [7:0] ADDR_RAM_HI = 8'hbf;
  localparam logic [7:0] ADDR_ROM_WINDOW = 8'hc9;
  localparam logic [7:0] ADDR_RAM_BANK = 8'hcb;
  localparam logic [7:0] ADDR_ACCUM = 8'hff;

  localparam logic [7:0] BANK_NONE = 8'h00;
  localparam logic [7:0] BANK_PAGE_ONE = 8'h08;
  localparam logic [7:0] BANK_PAGE_TWO = 8'h10;
  localparam int RAM_PAGE_ONE_BIT = 3;
  localparam int RAM_PAGE_TWO_BIT = 4;

  localparam logic [7:0] READ_IDLE = 8'h00;

  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_BANK,
    TGT_WINDOW,
    TGT_REG
  } target_t;
endpackage

// ---- dspace_if.sv ----
// read and write path between the decode top and the banked ram
interface bank_if;
  import dspace_pkg::*;
  logic [WIN_OFS_W-1:0] addr;
  logic [DATA_W-1:0]    wdata;
  logic                 we;
  logic                 page_one;
  logic                 page_two;
  logic [DATA_W-1:0]    rdata;
  modport ctrl (output addr, wdata, we, page_one, page_two, input rdata);
  modport mem  (input addr, wdata, we, page_one, page_two, output rdata);
endinterface

// ---- bank_ram.sv ----
// banked 64-byte ram pages behind the low data addresses
module bank_ram
  import dspace_pkg::*;
(
  // clock
  input  wire logic i_sys_clk,
  // access
  bank_if.mem       bus
);
  logic [DATA_W-1:0] page0 [BANK_DEPTH];
  logic [DATA_W-1:0] page1 [BANK_DEPTH];
  logic [DATA_W-1:0] page2 [BANK_DEPTH];
  logic [DATA_W-1:0] rd_or;

  // steer to selected bank
  // several set page bits write all of them and or the reads, as the part does
  always_ff @(posedge i_sys_clk) begin
    if (bus.we && !bus.page_one && !bus.page_two) page0[bus.addr] <= bus.wdata;
    if (bus.we && bus.page_one) page1[bus.addr] <= bus.wdata;
    if (bus.we && bus.page_two) page2[bus.addr] <= bus.wdata;
  end

  always_comb begin
    rd_or = '0;
    if (!bus.page_one && !bus.page_two) rd_or = page0[bus.addr];
    if (bus.page_one) rd_or = rd_or | page1[bus.addr];
    if (bus.page_two) rd_or = rd_or | page2[bus.addr];
  end

  assign bus.rdata = rd_or;
endmodule

// ---- dspace_map.sv ----
// data-space decode: rom window, ram banks and mapped core registers
//
// Function
// - write-only window select at c9, bits 6-0
// - window select not initialised by reset
// - write-only bank select at cb, bits 4,3
// - bank codes 00 none, 08 one, 10 two
// - addresses 00-3f go to selected bank
// - bank select unchanged by interrupt or call
// - accumulator mapped read/write at ff
// - pointer registers mapped at 80, 81
// - short-direct registers mapped at 82, 83
// - twelve-bit program counter, next location
// - reads 40-7f come from program memory
// - window address: select above low offset
module dspace_map
  import dspace_pkg::*;
(
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_arst_n,
  // core data-space access
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic                  i_rd,
  input  wire logic                  i_wr,
  input  wire logic [DATA_W-1:0]     i_wdata,
  output logic      [DATA_W-1:0]     o_rdata,
  output logic                       o_rvalid,
  // core program counter control
  input  wire logic                  i_pc_load,
  input  wire logic [PC_W-1:0]       i_pc_value,
  input  wire logic                  i_pc_inc,
  output logic      [PC_W-1:0]       o_pc,
  // program memory window port
  output logic      [ROM_ADDR_W-1:0] o_rom_addr,
  output logic                       o_rom_rd,
  input  wire logic [DATA_W-1:0]     i_rom_data,
  // selector values for observation
  output logic      [WIN_PAGE_W-1:0] o_rom_window_page_bits,
  output logic      [DATA_W-1:0]     o_ram_bank_select
);
  import dspace_pkg::*;

  function automatic target_t decode(input logic [ADDR_W-1:0] a);
    if (a <= ADDR_BANK_HI) return TGT_BANK;
    if (a >= ADDR_WIN_LO && a <= ADDR_WIN_HI) return TGT_WINDOW;
    return TGT_REG;
  endfunction

  bank_if bank ();

  logic [WIN_PAGE_W-1:0] rom_window_page_bits;
  logic [DATA_W-1:0]     ram_bank_select;
  logic [DATA_W-1:0]     accumulator;
  logic [DATA_W-1:0]     pointer_reg_first;
  logic [DATA_W-1:0]     pointer_reg_second;
  logic [DATA_W-1:0]     short_direct_first;
  logic [DATA_W-1:0]     short_direct_second;
  logic [DATA_W-1:0]     ram_hi [RAM_HI_DEPTH];
  logic [PC_W-1:0]       pc;
  target_t               rd_target;
  logic [ADDR_W-1:0]     rd_addr;
  logic [DATA_W-1:0]     next_reg_rdata;
  logic [DATA_W-1:0]     reg_rdata;
  logic                  rd_pending;
  logic                  is_ram_hi;
  logic [ADDR_W-1:0]     ram_hi_idx;

  assign is_ram_hi  = (i_addr >= ADDR_RAM_LO) && (i_addr <= ADDR_RAM_HI);
  assign ram_hi_idx = i_addr - ADDR_RAM_LO;

  // no reset term: content undefined until written
  always_ff @(posedge i_sys_clk) begin
    if (i_wr && i_addr == ADDR_ROM_WINDOW) rom_window_page_bits <= i_wdata[WIN_PAGE_W-1:0];
  end

  // only a write to cb alters it
  always_ff @(posedge i_sys_clk) begin
    if (i_wr && i_addr == ADDR_RAM_BANK) ram_bank_select <= i_wdata;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_wr && i_addr == ADDR_ACCUM) accumulator <= i_wdata;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_wr && i_addr == ADDR_PTR_FIRST) pointer_reg_first <= i_wdata;
    if (i_wr && i_addr == ADDR_PTR_SECOND) pointer_reg_second <= i_wdata;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_wr && i_addr == ADDR_SD_FIRST) short_direct_first <= i_wdata;
    if (i_wr && i_addr == ADDR_SD_SECOND) short_direct_second <= i_wdata;
  end

  // ordinary ram between the short-direct registers and the ports
  always_ff @(posedge i_sys_clk) begin
    if (i_wr && is_ram_hi) ram_hi[ram_hi_idx[WIN_OFS_W-1:0]] <= i_wdata;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc <= '0;
    end else if (i_pc_load) begin
      pc <= i_pc_value;
    end else if (i_pc_inc) begin
      pc <= pc + PC_W'(1);
    end
  end

  // bank access uses low six address bits
  // page bits taken straight from the decoded code
  assign bank.addr     = i_addr[WIN_OFS_W-1:0];
  assign bank.wdata    = i_wdata;
  assign bank.we       = i_wr && decode(i_addr) == TGT_BANK;
  assign bank.page_one = ram_bank_select[RAM_PAGE_ONE_BIT];
  assign bank.page_two = ram_bank_select[RAM_PAGE_TWO_BIT];

  bank_ram u_bank (
    .i_sys_clk (i_sys_clk),
    .bus       (bank.mem)
  );

  // window reads go to program memory
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rom_addr <= '0;
      o_rom_rd   <= 1'b0;
    end else begin
      o_rom_rd <= i_rd && decode(i_addr) == TGT_WINDOW;
      if (i_rd && decode(i_addr) == TGT_WINDOW)
        o_rom_addr <= {rom_window_page_bits, i_addr[WIN_OFS_W-1:0]};
    end
  end

  // write-only selectors and unmapped addresses read as idle
  always_comb begin
    next_reg_rdata = READ_IDLE;
    case (i_addr)
      ADDR_ACCUM:      next_reg_rdata = accumulator;
      ADDR_PTR_FIRST:  next_reg_rdata = pointer_reg_first;
      ADDR_PTR_SECOND: next_reg_rdata = pointer_reg_second;
      ADDR_SD_FIRST:   next_reg_rdata = short_direct_first;
      ADDR_SD_SECOND:  next_reg_rdata = short_direct_second;
      default: begin
        if (is_ram_hi) next_reg_rdata = ram_hi[ram_hi_idx[WIN_OFS_W-1:0]];
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_target  <= TGT_NONE;
      rd_addr    <= '0;
      reg_rdata  <= '0;
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= i_rd;
      rd_addr    <= i_addr;
      rd_target  <= i_rd ? decode(i_addr) : TGT_NONE;
      reg_rdata  <= next_reg_rdata;
    end
  end

  // second stage: window byte arrives one cycle after its address
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata  <= '0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= rd_pending;
      case (rd_target)
        TGT_BANK:   o_rdata <= bank.rdata;
        TGT_WINDOW: o_rdata <= i_rom_data;
        TGT_REG:    o_rdata <= reg_rdata;
        default:    o_rdata <= o_rdata;
      endcase
    end
  end

  // bank ram read uses the live address; hold it for one cycle after a read
  assign o_pc                   = pc;
  assign o_rom_window_page_bits = rom_window_page_bits;
  assign o_ram_bank_select      = ram_bank_select;
endmodule

// ---- rom_model.sv ----
// program memory stand-in answering window reads
module rom_model
  import dspace_pkg::*;
(
  // clock
  input  wire logic                  i_sys_clk,
  // window port
  input  wire logic                  i_rom_rd,
  input  wire logic [ROM_ADDR_W-1:0] i_rom_addr,
  output logic      [DATA_W-1:0]     o_rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] filler = 8'h5a;
  // filler toggles so stale data never looks right
  always @(posedge i_sys_clk) begin
    filler <= ~filler;
  end
  // byte stands while the fetch pulse does, taken at the next edge
  assign o_rom_data = i_rom_rd ? (i_rom_addr[7:0] ^ {3'h0, i_rom_addr[12:8]}) : filler;
endmodule

// ---- dspace_map_checker.sv ----
// concurrent checks on the data-space map ports
module dspace_map_checker
  import dspace_pkg::*;
(
  // clock and reset
  input wire logic                  i_sys_clk,
  input wire logic                  i_arst_n,
  // core side
  input wire logic [ADDR_W-1:0]     i_addr,
  input wire logic                  i_rd,
  input wire logic                  i_wr,
  input wire logic [DATA_W-1:0]     i_wdata,
  input wire logic [DATA_W-1:0]     o_rdata,
  input wire logic                  o_rvalid,
  input wire logic                  i_pc_load,
  input wire logic [PC_W-1:0]       i_pc_value,
  input wire logic                  i_pc_inc,
  input wire logic [PC_W-1:0]       o_pc,
  // window and selectors
  input wire logic [ROM_ADDR_W-1:0] o_rom_addr,
  input wire logic                  o_rom_rd,
  input wire logic [DATA_W-1:0]     i_rom_data,
  input wire logic [WIN_PAGE_W-1:0] o_rom_window_page_bits,
  input wire logic [DATA_W-1:0]     o_ram_bank_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  a_rvalid_two_edges: assert property (i_rd |-> ##2 o_rvalid)
    else $error("read answer missing two cycles after request");
  a_window_fetch_pulse: assert property (i_rd && i_addr[7:6] == 2'b01 |=> o_rom_rd)
    else $error("window read did not fetch program memory");
  a_window_addr_form: assert property (i_rd && i_addr[7:6] == 2'b01 |=>
    o_rom_addr == {$past(o_rom_window_page_bits), $past(i_addr[5:0])})
    else $error("window address not page above offset");
  a_window_data_return: assert property (o_rom_rd |=>
    o_rvalid && o_rdata == $past(i_rom_data))
    else $error("window byte not returned");
  a_window_sel_write: assert property (i_wr && i_addr == ADDR_ROM_WINDOW |=>
    o_rom_window_page_bits == $past(i_wdata[6:0]))
    else $error("window select not loaded from bits 6-0");
  a_bank_sel_write: assert property (i_wr && i_addr == ADDR_RAM_BANK |=>
    o_ram_bank_select == $past(i_wdata))
    else $error("bank select not loaded");
  a_bank_sel_hold: assert property (o_ram_bank_select != $past(o_ram_bank_select) |->
    $past(i_wr && i_addr == ADDR_RAM_BANK))
    else $error("bank select changed without a write");
  a_pc_load_value: assert property (i_pc_load |=> o_pc == $past(i_pc_value))
    else $error("program counter load wrong");
  a_pc_step_wrap: assert property (!i_pc_load && i_pc_inc |=> o_pc == $past(o_pc) + 12'h001)
    else $error("program counter step wrong");
endmodule
bind dspace_map dspace_map_checker dspace_map_checker_inst (.*);

// ---- testbench.sv ----
// self-checking bench for the data-space map
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dspace_pkg::*;
  logic i_sys_clk, i_arst_n, i_rd, i_wr, i_pc_load, i_pc_inc, o_rvalid, o_rom_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, i_rom_data, o_ram_bank_select;
  logic [11:0] i_pc_value, o_pc;
  logic [12:0] o_rom_addr;
  logic [6:0] o_rom_window_page_bits;
  int err_count = 0;
  int checked = 0;
  logic [7:0] regs [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
  logic [7:0] codes [3] = '{BANK_NONE, BANK_PAGE_ONE, BANK_PAGE_TWO};
  logic [6:0] pages [3] = '{7'h00, 7'h7f, 7'h2a};
  dspace_map dspace_map_inst (.*);
  rom_model rom_model_inst (.i_sys_clk(i_sys_clk), .i_rom_rd(o_rom_rd),
    .i_rom_addr(o_rom_addr), .o_rom_data(i_rom_data));
  initial begin
    i_sys_clk = 0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    // let the write settle before any compare of the selectors
    #1;
  endtask
  // address held after the request, bank reads use it one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    for (int n = 0; n < 5; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_rvalid === 1'b1) begin
        chk("rdata", exp, o_rdata);
        return;
      end
    end
    err_count++;
    end_of_test();
  endtask
  initial begin
    {i_arst_n, i_rd, i_wr, i_pc_load, i_pc_inc, i_addr, i_wdata, i_pc_value} = '0;
    repeat (10) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    #1;
    chk("pc", 12'h000, o_pc);
    foreach (regs[k]) wr(regs[k], 8'ha0 + 8'(k));
    foreach (regs[k]) rd(regs[k], 8'ha0 + 8'(k));
    // bank select written before any bank access
    // only codes 00, 08 and 10, always full-byte writes
    // selects changed only from the main flow, never an isr
    foreach (codes[k]) begin
      wr(ADDR_RAM_BANK, codes[k]);
      chk("bank select", codes[k], o_ram_bank_select);
      wr(8'h00, 8'hc0 + 8'(k));
      wr(8'h3f, 8'hd0 + 8'(k));
    end
    // each bank keeps its own bytes at 00 and 3f
    foreach (codes[k]) begin
      wr(ADDR_RAM_BANK, codes[k]);
      rd(8'h00, 8'hc0 + 8'(k));
      rd(8'h3f, 8'hd0 + 8'(k));
    end
    rd(ADDR_RAM_BANK, READ_IDLE);
    rd(8'hc0, READ_IDLE);
    // window select is only ever written as a whole byte, never read
    foreach (pages[k]) begin
      wr(ADDR_ROM_WINDOW, {1'b1, pages[k]});
      chk("window bits", pages[k], o_rom_window_page_bits);
      rd(8'h40, {pages[k][1:0], 6'h00} ^ {3'h0, pages[k][6:2]});
      rd(8'h7f, {pages[k][1:0], 6'h3f} ^ {3'h0, pages[k][6:2]});
    end
    rd(8'hca, READ_IDLE);
    @(posedge i_sys_clk);
    {i_pc_load, i_pc_value} <= {1'b1, 12'hffe};
    @(posedge i_sys_clk);
    {i_pc_load, i_pc_inc} <= 2'b01;
    #1;
    chk("pc", 12'hffe, o_pc);
    repeat (2) @(posedge i_sys_clk);
    i_pc_inc <= 1'b0;
    #1;
    chk("pc", 12'h000, o_pc);
    chk("bank select", BANK_PAGE_TWO, o_ram_bank_select);
    end_of_test();
  end
endmodule
